// >>> design/iolpw_pkg.sv
// Constants, types and carriers for the interrupt option and low-power wake block.
package iolpw_pkg;

	// Register map, byte addresses on the 32-bit register bus.
	localparam logic [31:0] IOLPW_OPT_ADDR = 32'h0000_00C8;
	localparam logic [31:0] IOLPW_STATUS_ADDR = 32'h0000_00CC;

	// Option register layout and reset value.
	localparam logic [7:0] IOLPW_OPT_RESET = 8'h00;
	localparam logic [7:0] IOLPW_OPT_MASK = 8'h70;
	localparam int IOLPW_LES_BIT = 6;
	localparam int IOLPW_POL_BIT = 5;
	localparam int IOLPW_GEN_BIT = 4;

	// Status register layout.
	localparam int IOLPW_ST_SLEEP_LSB = 0;
	localparam int IOLPW_ST_MODE_LSB = 2;
	localparam int IOLPW_ST_LATCH_LSB = 4;
	localparam int IOLPW_ST_OPT_LSB = 8;

	// Bus answers.
	localparam logic [1:0] IOLPW_RESP_OKAY = 2'h0;
	localparam logic [1:0] IOLPW_RESP_SLVERR = 2'h2;
	localparam logic [1:0] IOLPW_RESP_DECERR = 2'h3;

	// Oscillator stabilisation after a wake from STOP, rounded up to cycles.
	localparam int IOLPW_CLK_MHZ = 250;
	localparam int IOLPW_OSC_STAB_NS = 4000;
	localparam int IOLPW_STAB_CYCLES_INT =
		(IOLPW_OSC_STAB_NS * IOLPW_CLK_MHZ + 999) / 1000;
	localparam logic [9:0] IOLPW_STAB_LAST =
		10'(IOLPW_STAB_CYCLES_INT - 1);

	// Interrupt source numbers; source 0 is the non-maskable one.
	localparam logic [2:0] IOLPW_SRC_NMI = 3'h0;

	typedef enum logic [1:0] {
		IOLPW_RUN = 2'h0,
		IOLPW_WAIT = 2'h1,
		IOLPW_STOP = 2'h2,
		IOLPW_STAB = 2'h3
	} iolpw_sleep_type;

	typedef enum logic [1:0] {
		IOLPW_NORMAL = 2'h0,
		IOLPW_INT = 2'h1,
		IOLPW_NMI = 2'h2
	} iolpw_mode_type;

	typedef struct packed {
		logic awvalid;
		logic [31:0] awaddr;
		logic [2:0] awprot;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [31:0] araddr;
		logic [2:0] arprot;
		logic rready;
	} iolpw_axil_req_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} iolpw_axil_rsp_type;

endpackage : iolpw_pkg

// >>> design/iolpw_ctrl.sv
// Interrupt option register, request detection and sleep/wake sequencer.
// Summary of operation
// - option register takes full-byte writes only.
// - option register clears to zero on reset.
// - bit 7 and bits 3..0 do nothing.
// - bit 6 picks level or edge for source 1.
// - bit 5 picks the edge of source 2.
// - bit 5 high rising, low falling edge.
// - bit 4 low masks all but NMI.
// - bit 4 low: nothing wakes, only reset.
// - return restores previous flag set and mode.
// - WAIT halts core, oscillator keeps running.
// - wake from WAIT has no stabilisation delay.
// - reset during sleep runs ordinary reset.
// - STOP halts oscillator, waits for interrupt.
// - wake from STOP waits for oscillator stabilisation.
// - active watchdog turns STOP into WAIT.
// - main-routine sleeper services waking interrupt first.
// - NMI-routine sleeper resumes, stays in NMI mode.
// - interrupt-routine sleeper finishes routine before others.
// - NMI wakes interrupt routine: NMI first, stays.
// - no sleep while enabled request is pending.
// - wake leaves oscillator source selection alone.
`timescale 1ns/1ps

module iolpw_ctrl
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire iolpw_pkg::iolpw_axil_req_type axi_req_i,
	output iolpw_pkg::iolpw_axil_rsp_type axi_rsp_o,
	input wire logic [4:0] src_n_i,
	input wire logic wait_instr_i,
	input wire logic stop_instr_i,
	input wire logic watchdog_active_i,
	input wire logic core_ack_i,
	input wire logic [2:0] core_ack_id_i,
	input wire logic return_from_interrupt_i,
	output logic irq_valid_o,
	output logic [2:0] irq_id_o,
	output logic [1:0] flag_set_o,
	output logic core_halt_o,
	output logic osc_run_o,
	output logic resume_o,
	output logic sleep_refused_o
);

	typedef struct packed {
		logic aw_got;
		logic [31:0] aw_addr;
		logic w_got;
		logic [7:0] w_data;
		logic w_strb0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [7:0] opt;
		logic [4:0] sync1;
		logic [4:0] sync2;
		logic [4:0] prev;
		logic [2:0] latch;
		iolpw_pkg::iolpw_sleep_type sleep;
		logic [9:0] stab_cnt;
		iolpw_pkg::iolpw_mode_type mode;
		iolpw_pkg::iolpw_mode_type saved_mode;
		logic irq_valid;
		logic [2:0] irq_id;
		logic resume;
		logic refused;
	} iolpw_state_type;

	iolpw_state_type state_q;
	iolpw_state_type state_d;

	logic gen;
	logic level_edge_select;
	logic pol;
	logic [4:0] fall;
	logic [4:0] rise;
	logic [4:0] req;
	logic pend;
	logic wake;
	logic sleep_req;
	logic cand_v;
	logic [2:0] cand_id;
	logic [2:0] latch_set;
	logic [2:0] latch_clr;

	assign gen = state_q.opt[iolpw_pkg::IOLPW_GEN_BIT];
	assign level_edge_select = state_q.opt[iolpw_pkg::IOLPW_LES_BIT];
	assign pol = state_q.opt[iolpw_pkg::IOLPW_POL_BIT];

	// Pins are active low; edges are seen after the two-stage synchroniser.
	assign fall = state_q.prev & ~state_q.sync2;
	assign rise = ~state_q.prev & state_q.sync2;

	always_comb
	begin
		latch_set[0] = fall[0];
		latch_set[1] = ~level_edge_select & fall[1];
		latch_set[2] = pol ? rise[2] : fall[2];
		for (int i = 0; i < 3; i++)
		begin
			latch_clr[i] = core_ack_i && (core_ack_id_i == 3'(i));
		end
	end

	// Source 0 is never masked; the others need the global enable.
	assign req[0] = state_q.latch[0];
	assign req[1] = gen & (level_edge_select ? ~state_q.sync2[1] : state_q.latch[1]);
	assign req[2] = gen & state_q.latch[2];
	assign req[3] = gen & ~state_q.sync2[3];
	assign req[4] = gen & ~state_q.sync2[4];
	assign pend = |req;
	// A pending NMI still cannot wake the core while the enable is low.
	assign wake = gen & (|req);
	assign sleep_req = wait_instr_i | stop_instr_i;

	// Selection of the request offered to the core.
	always_comb
	begin
		cand_v = 1'b0;
		cand_id = 3'h0;
		if (state_q.latch[0] && state_q.mode != iolpw_pkg::IOLPW_NMI)
		begin
			cand_v = 1'b1;
			cand_id = iolpw_pkg::IOLPW_SRC_NMI;
		end
		else if (state_q.mode == iolpw_pkg::IOLPW_NORMAL)
		begin
			// Lowest number wins, so scan from the bottom priority up.
			for (int i = 4; i >= 1; i--)
			begin
				if (req[i])
				begin
					cand_v = 1'b1;
					cand_id = 3'(i);
				end
			end
		end
	end

	always_comb
	begin
		state_d = state_q;
		state_d.resume = 1'b0;
		state_d.refused = 1'b0;

		// The first stage feeds only the second stage.
		state_d.sync1 = src_n_i;
		state_d.sync2 = state_q.sync1;
		state_d.prev = state_q.sync2;

		// Edge latches: a new edge wins over the core's clear.
		for (int i = 0; i < 3; i++)
		begin
			state_d.latch[i] = latch_set[i] |
				(state_q.latch[i] & ~latch_clr[i]);
		end
		if (level_edge_select)
		begin
			state_d.latch[1] = 1'b0;
		end

		// Write address and data are taken in either order.
		if (axi_req_i.awvalid && !state_q.aw_got && !state_q.bvalid)
		begin
			state_d.aw_got = 1'b1;
			state_d.aw_addr = axi_req_i.awaddr;
		end
		if (axi_req_i.wvalid && !state_q.w_got && !state_q.bvalid)
		begin
			state_d.w_got = 1'b1;
			state_d.w_data = axi_req_i.wdata[7:0];
			state_d.w_strb0 = axi_req_i.wstrb[0];
		end
		if (state_q.aw_got && state_q.w_got && !state_q.bvalid)
		begin
			state_d.aw_got = 1'b0;
			state_d.w_got = 1'b0;
			state_d.bvalid = 1'b1;
			if (state_q.aw_addr == iolpw_pkg::IOLPW_OPT_ADDR)
			begin
				if (state_q.w_strb0)
				begin
					state_d.opt = state_q.w_data &
						iolpw_pkg::IOLPW_OPT_MASK;
					state_d.bresp = iolpw_pkg::IOLPW_RESP_OKAY;
				end
				else
				begin
					// A write missing the low byte lane leaves the register alone.
					state_d.bresp = iolpw_pkg::IOLPW_RESP_SLVERR;
				end
			end
			else if (state_q.aw_addr == iolpw_pkg::IOLPW_STATUS_ADDR)
			begin
				state_d.bresp = iolpw_pkg::IOLPW_RESP_SLVERR;
			end
			else
			begin
				state_d.bresp = iolpw_pkg::IOLPW_RESP_DECERR;
			end
		end
		if (state_q.bvalid && axi_req_i.bready)
		begin
			state_d.bvalid = 1'b0;
		end

		// Reads: the option register is write only and refuses them.
		if (axi_req_i.arvalid && !state_q.rvalid)
		begin
			state_d.rvalid = 1'b1;
			state_d.rdata = 32'h0000_0000;
			if (axi_req_i.araddr == iolpw_pkg::IOLPW_OPT_ADDR)
			begin
				state_d.rresp = iolpw_pkg::IOLPW_RESP_SLVERR;
			end
			else if (axi_req_i.araddr == iolpw_pkg::IOLPW_STATUS_ADDR)
			begin
				state_d.rresp = iolpw_pkg::IOLPW_RESP_OKAY;
				state_d.rdata[iolpw_pkg::IOLPW_ST_SLEEP_LSB +: 2] =
					state_q.sleep;
				state_d.rdata[iolpw_pkg::IOLPW_ST_MODE_LSB +: 2] =
					state_q.mode;
				state_d.rdata[iolpw_pkg::IOLPW_ST_LATCH_LSB +: 3] =
					state_q.latch;
				state_d.rdata[iolpw_pkg::IOLPW_ST_OPT_LSB +: 8] =
					state_q.opt;
			end
			else
			begin
				state_d.rresp = iolpw_pkg::IOLPW_RESP_DECERR;
			end
		end
		else if (state_q.rvalid && axi_req_i.rready)
		begin
			state_d.rvalid = 1'b0;
		end

		// Mode tracking: a return restores the set in use before entry.
		if (return_from_interrupt_i)
		begin
			state_d.mode = (state_q.mode == iolpw_pkg::IOLPW_NMI) ?
				state_q.saved_mode : iolpw_pkg::IOLPW_NORMAL;
		end
		if (core_ack_i)
		begin
			if (core_ack_id_i == iolpw_pkg::IOLPW_SRC_NMI)
			begin
				// Remember normal or interrupt mode under the NMI.
				state_d.saved_mode = state_q.mode;
				state_d.mode = iolpw_pkg::IOLPW_NMI;
			end
			else
			begin
				state_d.mode = iolpw_pkg::IOLPW_INT;
			end
		end

		// Sleep sequencer.
		unique case (state_q.sleep)
			iolpw_pkg::IOLPW_RUN:
			begin
				if (sleep_req)
				begin
					if (pend)
					begin
						state_d.refused = 1'b1;
					end
					else if (stop_instr_i && !watchdog_active_i)
					begin
						state_d.sleep = iolpw_pkg::IOLPW_STOP;
					end
					else
					begin
						state_d.sleep = iolpw_pkg::IOLPW_WAIT;
					end
				end
			end
			iolpw_pkg::IOLPW_WAIT:
			begin
				// The clock never stopped, so execution restarts at once.
				// Waking never touches the oscillator source selection.
				if (wake)
				begin
					state_d.sleep = iolpw_pkg::IOLPW_RUN;
					state_d.resume = 1'b1;
				end
			end
			iolpw_pkg::IOLPW_STOP:
			begin
				if (wake)
				begin
					state_d.sleep = iolpw_pkg::IOLPW_STAB;
					state_d.stab_cnt = iolpw_pkg::IOLPW_STAB_LAST;
				end
			end
			iolpw_pkg::IOLPW_STAB:
			begin
				if (state_q.stab_cnt == 10'h000)
				begin
					state_d.sleep = iolpw_pkg::IOLPW_RUN;
					state_d.resume = 1'b1;
				end
				else
				begin
					state_d.stab_cnt = state_q.stab_cnt - 10'h001;
				end
			end
		endcase

		// A request is offered only while the core executes; in NMI mode
		// nothing is offered, so a waking request is left pending.
		state_d.irq_valid = cand_v && !core_ack_i &&
			state_q.sleep == iolpw_pkg::IOLPW_RUN;
		state_d.irq_id = cand_id;
	end

	// Any reset, pin or watchdog, lands here and restarts from scratch.
	always_ff @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			state_q <= '0;
			// Pins idle high; starting the detectors there avoids a false
			// rising edge on every source just after reset.
			state_q.sync1 <= 5'h1F;
			state_q.sync2 <= 5'h1F;
			state_q.prev <= 5'h1F;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	// One process drives the whole response struct.
	always_comb
	begin
		axi_rsp_o.awready = !state_q.aw_got && !state_q.bvalid;
		axi_rsp_o.wready = !state_q.w_got && !state_q.bvalid;
		axi_rsp_o.bvalid = state_q.bvalid;
		axi_rsp_o.bresp = state_q.bresp;
		axi_rsp_o.arready = !state_q.rvalid;
		axi_rsp_o.rvalid = state_q.rvalid;
		axi_rsp_o.rdata = state_q.rdata;
		axi_rsp_o.rresp = state_q.rresp;
	end

	assign irq_valid_o = state_q.irq_valid;
	assign irq_id_o = state_q.irq_id;
	assign flag_set_o = state_q.mode;
	assign core_halt_o = state_q.sleep != iolpw_pkg::IOLPW_RUN;
	// The oscillator only stops in STOP; peripherals keep clocking in WAIT.
	assign osc_run_o = state_q.sleep != iolpw_pkg::IOLPW_STOP;
	assign resume_o = state_q.resume;
	assign sleep_refused_o = state_q.refused;

	default clocking chk_cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	chk_opt_reset_zero: assert property (disable iff (1'b0)
		sys_rst_i |-> state_q.opt == 8'h00)
		else $error("option register not clear under reset");

	chk_opt_unused_bits: assert property (
		(state_q.opt & ~iolpw_pkg::IOLPW_OPT_MASK) == 8'h00)
		else $error("unused option bits became set");

	chk_opt_read_refused: assert property (
		axi_req_i.arvalid && !state_q.rvalid &&
		axi_req_i.araddr == iolpw_pkg::IOLPW_OPT_ADDR
		|=> state_q.rvalid && state_q.rresp == 2'h2 &&
		state_q.rdata == 32'h0000_0000)
		else $error("option register read was not refused");

	chk_partial_ignored: assert property (
		$rose(state_q.bvalid) && state_q.bresp == 2'h2 |->
		$stable(state_q.opt))
		else $error("refused write changed the option register");

	chk_level_src_one: assert property (
		level_edge_select && gen && !state_q.sync2[1] && !state_q.latch[0] &&
		state_q.mode == iolpw_pkg::IOLPW_NORMAL &&
		state_q.sleep == iolpw_pkg::IOLPW_RUN && !core_ack_i |=>
		irq_valid_o && irq_id_o == 3'h1)
		else $error("level request on source 1 not offered");

	chk_edge_src_two: assert property (
		pol && !state_q.prev[2] && state_q.sync2[2] |=> state_q.latch[2])
		else $error("rising edge on source 2 not latched");

	chk_gen_masks: assert property (
		!gen && !state_q.latch[0] |=> !irq_valid_o)
		else $error("maskable request offered while disabled");

	chk_no_wake_gated: assert property (
		state_q.sleep == iolpw_pkg::IOLPW_WAIT && !gen |=>
		state_q.sleep == iolpw_pkg::IOLPW_WAIT)
		else $error("core woke while global enable was low");

	chk_wait_fast_wake: assert property (
		state_q.sleep == iolpw_pkg::IOLPW_WAIT && wake |=>
		state_q.sleep == iolpw_pkg::IOLPW_RUN && resume_o)
		else $error("wake from wait was delayed");

	chk_stop_stab_hold: assert property (
		state_q.sleep == iolpw_pkg::IOLPW_STOP && wake |=>
		(state_q.sleep == iolpw_pkg::IOLPW_STAB && !resume_o)[*8])
		else $error("stabilisation delay cut short");

	chk_osc_in_stop: assert property (
		state_q.sleep == iolpw_pkg::IOLPW_STOP |-> !osc_run_o &&
		core_halt_o)
		else $error("oscillator running in stop");

	chk_wdog_stop_wait: assert property (
		state_q.sleep == iolpw_pkg::IOLPW_RUN && stop_instr_i &&
		watchdog_active_i && !pend |=>
		state_q.sleep == iolpw_pkg::IOLPW_WAIT && osc_run_o)
		else $error("stop entered with watchdog active");

	chk_pending_no_sleep: assert property (
		state_q.sleep == iolpw_pkg::IOLPW_RUN && sleep_req && pend |=>
		state_q.sleep == iolpw_pkg::IOLPW_RUN && sleep_refused_o)
		else $error("sleep entered with request pending");

	chk_nmi_mode_quiet: assert property (
		state_q.mode == iolpw_pkg::IOLPW_NMI &&
		$past(state_q.mode) == iolpw_pkg::IOLPW_NMI |-> !irq_valid_o)
		else $error("request offered inside the nmi routine");

	chk_return_restore: assert property (
		return_from_interrupt_i && !core_ack_i &&
		state_q.mode == iolpw_pkg::IOLPW_INT |=>
		flag_set_o == 2'h0)
		else $error("return did not restore normal flag set");

	cov_wait_wake: cover property (
		state_q.sleep == iolpw_pkg::IOLPW_WAIT ##1 resume_o);
	cov_stop_wake: cover property (
		state_q.sleep == iolpw_pkg::IOLPW_STAB ##1
		state_q.sleep == iolpw_pkg::IOLPW_RUN);
	cov_nmi_in_int: cover property (
		state_q.mode == iolpw_pkg::IOLPW_INT && core_ack_i &&
		core_ack_id_i == 3'h0);
	cov_opt_write: cover property (
		$rose(state_q.bvalid) && state_q.bresp == 2'h0);

endmodule : iolpw_ctrl

// >>> verif/iolpw_core_model.sv
// Behavioural processor core that takes offered interrupts and returns.
`timescale 1ns/1ps

module iolpw_core_model
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic serve_i,
	input wire logic slow_i,
	input wire logic irq_valid_i,
	input wire logic [2:0] irq_id_i,
	output logic ack_o,
	output logic [2:0] ack_id_o,
	output logic ret_o,
	output logic busy_o
);
	int wt;
	int rt;

	assign busy_o = (wt != 0) || (rt != 0);

	// A slow core lets a request wait, as a long instruction would.
	always @(posedge clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			wt <= 0;
			rt <= 0;
			ack_o <= 1'b0;
			ack_id_o <= 3'h0;
			ret_o <= 1'b0;
		end
		else
		begin
			ack_o <= 1'b0;
			ret_o <= 1'b0;
			if (wt != 0)
			begin
				wt <= wt - 1;
				if (wt == 1 && irq_valid_i)
				begin
					ack_o <= 1'b1;
					ack_id_o <= irq_id_i;
					rt <= 6;
				end
			end
			else if (rt != 0)
			begin
				rt <= rt - 1;
				ret_o <= (rt == 1);
			end
			else if (serve_i && irq_valid_i)
				wt <= slow_i ? 8 : 1;
		end
	end
endmodule : iolpw_core_model

// >>> verif/interrupt_option_low_power_wake_test.sv
// Self-checking bench for the interrupt option and low-power wake block.
`timescale 1ns/1ps

module interrupt_option_low_power_wake_test;
	localparam logic [31:0] OPT = iolpw_pkg::IOLPW_OPT_ADDR;
	localparam logic [31:0] STAT = iolpw_pkg::IOLPW_STATUS_ADDR;
	localparam logic [1:0] R_OK = iolpw_pkg::IOLPW_RESP_OKAY;
	localparam logic [1:0] R_SLV = iolpw_pkg::IOLPW_RESP_SLVERR;
	localparam logic [1:0] R_DEC = iolpw_pkg::IOLPW_RESP_DECERR;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b0;
	iolpw_pkg::iolpw_axil_req_type req = '0;
	iolpw_pkg::iolpw_axil_rsp_type rsp;
	logic [4:0] src_n = 5'h1F;
	logic wait_in = 1'b0;
	logic stop_in = 1'b0;
	logic wdog = 1'b0;
	logic serve = 1'b0;
	logic slow = 1'b0;
	logic ack;
	logic [2:0] ack_id;
	logic ret;
	logic busy;
	logic irq_valid;
	logic [2:0] irq_id;
	logic [1:0] flag_set;
	logic halt;
	logic osc_run;
	logic resume;
	logic refused;
	logic refused_seen;
	logic [7:0] opt_m = 8'h00;
	logic [31:0] rd;
	int c;
	int n_fail = 0;
	int n_checks = 0;

	always #2 clk_i = ~clk_i;

	iolpw_ctrl iolpw_ctrl_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.axi_req_i(req), .axi_rsp_o(rsp), .src_n_i(src_n),
		.wait_instr_i(wait_in), .stop_instr_i(stop_in),
		.watchdog_active_i(wdog), .core_ack_i(ack), .core_ack_id_i(ack_id),
		.return_from_interrupt_i(ret), .irq_valid_o(irq_valid),
		.irq_id_o(irq_id), .flag_set_o(flag_set), .core_halt_o(halt),
		.osc_run_o(osc_run), .resume_o(resume), .sleep_refused_o(refused));

	iolpw_core_model iolpw_core_model_i (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .serve_i(serve), .slow_i(slow),
		.irq_valid_i(irq_valid), .irq_id_i(irq_id), .ack_o(ack),
		.ack_id_o(ack_id), .ret_o(ret), .busy_o(busy));

	task automatic stop_test;
		if (n_fail == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic give_up;
		check(32'h0, 32'h1);
		stop_test();
	endtask : give_up

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick

	// Address and data go out together; each is dropped once taken.
	task automatic wr(input logic [31:0] a, input logic [7:0] d,
		input logic [3:0] s, input logic [1:0] er);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= {24'h000000, d};
		req.wstrb <= s;
		req.bready <= 1'b1;
		while (!done)
		begin
			@(posedge clk_i);
			if (req.awvalid && rsp.awready)
				req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready)
				req.wvalid <= 1'b0;
			if (rsp.bvalid === 1'b1)
			begin
				req.bready <= 1'b0;
				done = 1'b1;
				check(32'(rsp.bresp), 32'(er));
			end
			if (++n > 100)
				give_up();
		end
		// One edge passes so that a following call may raise bready again.
		@(posedge clk_i);
		if (a == OPT && er == R_OK)
			opt_m = d & 8'h70;
	endtask : wr

	task automatic rdr(input logic [31:0] a, input logic [1:0] er);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		while (!done)
		begin
			@(posedge clk_i);
			if (req.arvalid && rsp.arready)
				req.arvalid <= 1'b0;
			if (rsp.rvalid === 1'b1)
			begin
				req.rready <= 1'b0;
				done = 1'b1;
				rd = rsp.rdata;
				check(32'(rsp.rresp), 32'(er));
			end
			if (++n > 100)
				give_up();
		end
		@(posedge clk_i);
	endtask : rdr

	task automatic wr_opt(input logic [7:0] d);
		wr(OPT, d, 4'hF, R_OK);
	endtask : wr_opt

	task automatic status(input logic [1:0] sl);
		rdr(STAT, R_OK);
		check(32'(rd[15:8]), 32'(opt_m));
		check(32'(rd[1:0]), 32'(sl));
	endtask : status

	task automatic pin(input int i, input logic v);
		src_n[i] <= v;
		tick(1);
	endtask : pin

	task automatic sleep(input logic stop);
		if (stop)
			stop_in <= 1'b1;
		else
			wait_in <= 1'b1;
		@(posedge clk_i);
		stop_in <= 1'b0;
		wait_in <= 1'b0;
		@(posedge clk_i);
		refused_seen = refused;
	endtask : sleep

	task automatic wait_irq(input logic [2:0] id);
		int n;
		n = 0;
		while (irq_valid !== 1'b1)
		begin
			tick(1);
			if (++n > 20)
				give_up();
		end
		check(32'(irq_id), 32'(id));
	endtask : wait_irq

	// The first cycles are skipped: the pins pass a synchroniser first.
	task automatic no_irq;
		logic seen;
		seen = 1'b0;
		tick(4);
		repeat (10)
		begin
			tick(1);
			seen |= irq_valid;
		end
		check(32'(seen), 32'h0);
	endtask : no_irq

	task automatic wait_res;
		c = 0;
		while (resume !== 1'b1)
		begin
			tick(1);
			if (++c > 1100)
				give_up();
		end
	endtask : wait_res

	task automatic serve_all;
		int n;
		logic got;
		logic [1:0] m;
		n = 0;
		got = 1'b0;
		m = (irq_id == 3'h0) ? 2'h2 : 2'h1;
		serve <= 1'b1;
		while (!got || busy)
		begin
			tick(1);
			if (++n > 40)
				give_up();
			if (ack === 1'b1)
			begin
				got = 1'b1;
				tick(1);
				check(32'(flag_set), 32'(m));
				serve <= 1'b0;
			end
		end
		tick(1);
		check(32'(flag_set), 32'h0);
	endtask : serve_all

	task automatic do_reset;
		sys_rst_i <= 1'b1;
		tick(10);
		sys_rst_i <= 1'b0;
		opt_m = 8'h00;
		tick(4);
	endtask : do_reset

	initial
	begin
		logic [7:0] d;
		logic [3:0] s;
		void'($urandom(6250));
		do_reset();
		status(2'h0);
		rdr(OPT, R_SLV);
		check(rd, 32'h0);
		rdr(32'h0000_00C4, R_DEC);
		wr(32'h0000_0104, 8'h10, 4'hF, R_DEC);
		wr(STAT, 8'h10, 4'hF, R_SLV);
		repeat (8)
		begin
			d = 8'($urandom);
			s = 4'($urandom);
			wr(OPT, d, s, s[0] ? R_OK : R_SLV);
			status(2'h0);
		end
		wr_opt(8'h10);
		pin(1, 1'b0);
		pin(1, 1'b1);
		wait_irq(3'h1);
		serve_all();
		wr_opt(8'h50);
		pin(1, 1'b0);
		wait_irq(3'h1);
		pin(1, 1'b1);
		no_irq();
		wr_opt(8'h30);
		pin(2, 1'b0);
		no_irq();
		pin(2, 1'b1);
		wait_irq(3'h2);
		serve_all();
		wr_opt(8'h10);
		pin(2, 1'b0);
		wait_irq(3'h2);
		pin(2, 1'b1);
		serve_all();
		wr_opt(8'h00);
		pin(3, 1'b0);
		no_irq();
		pin(0, 1'b0);
		wait_irq(3'h0);
		pin(0, 1'b1);
		pin(3, 1'b1);
		serve_all();
		wr_opt(8'h10);
		sleep(1'b0);
		check(32'({halt, osc_run}), 32'h3);
		pin(1, 1'b0);
		wait_res();
		check(32'(c < 8), 32'h1);
		pin(1, 1'b1);
		wait_irq(3'h1);
		serve_all();
		slow <= 1'b1;
		sleep(1'b1);
		check(32'({halt, osc_run}), 32'h2);
		pin(1, 1'b0);
		wait_res();
		check(32'(c >= iolpw_pkg::IOLPW_STAB_CYCLES_INT), 32'h1);
		check(32'(c < 1012), 32'h1);
		pin(1, 1'b1);
		wait_irq(3'h1);
		serve_all();
		slow <= 1'b0;
		wdog <= 1'b1;
		sleep(1'b1);
		check(32'({halt, osc_run}), 32'h3);
		pin(1, 1'b0);
		wait_res();
		check(32'(c < 8), 32'h1);
		pin(1, 1'b1);
		wait_irq(3'h1);
		serve_all();
		wdog <= 1'b0;
		pin(3, 1'b0);
		wait_irq(3'h3);
		sleep(1'b0);
		check(32'({refused_seen, halt}), 32'h2);
		pin(3, 1'b1);
		wr_opt(8'h00);
		sleep(1'b0);
		pin(0, 1'b0);
		no_irq();
		check(32'(halt), 32'h1);
		pin(0, 1'b1);
		do_reset();
		check(32'({halt, osc_run}), 32'h1);
		status(2'h0);
		stop_test();
	end
endmodule : interrupt_option_low_power_wake_test
